// *** cie_pkg.sv ***
// Package for the CPU interrupt entry and exit block: constants and carriers
// Summary of operation
// - Take interrupt only if source and global enabled
// - Vectors sit at lowest addresses, reset separate
// - Lowest vector wins; reset first, then ext0
// - Vector select bit moves vectors to boot
// - Boot reset fuse starts execution at boot
// - Boot lock bits suppress interrupts by counter
// - Entry clears global enable bit
// - Global enable inside handler allows nesting
// - Return: four cycles, pop two bytes, set enable
// - Entry clears flag of flag-type source
// - Writing one clears flag; zero keeps it
// - Disabled source still sets and holds flag
// - Pending flags served by priority when enabled
// - Level sources request only while condition present
// - One instruction runs after return before service
// - Status register not saved nor restored
// - Clear-enable instruction blocks same-cycle interrupts
// - Next instruction runs after set-enable first
// - Entry takes four cycles, pushes counter
// - Multi-cycle instruction finishes before service
// - Wake from sleep adds four entry cycles
// - Program counter 13 bits, 8K word memory
// - Push on entry lowers stack pointer by two
package cie_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int PC_W = 13;           // Word address width, 8K x 16
    localparam int SP_W = 16;           // Stack pointer width
    localparam int NUM_SRC = 8;         // Interrupt sources handled

    // ----------------------------------------
    // Vector layout and timing
    // ----------------------------------------
    localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;   // Reset vector
    localparam logic [PC_W-1:0] VEC_BASE = 13'h0002;    // First interrupt vector
    localparam int VEC_STEP = 2;                        // Words per vector slot
    localparam logic [SP_W-1:0] SP_RESET = 16'h0000;    // Stack pointer reset value
    localparam logic [SP_W-1:0] SP_STEP = 16'h0002;     // Return address bytes
    localparam logic [2:0] ENTRY_CYC = 3'h4;            // Entry cycles
    localparam logic [2:0] RETURN_FROM_INTERRUPT_CYC = 3'h4;             // Return cycles
    localparam logic [2:0] WAKE_EXTRA = 3'h4;           // Extra entry cycles after sleep

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    // Stack write request toward the data memory
    typedef struct packed {
        logic             valid;        // One-cycle write strobe
        logic [SP_W-1:0]  addr;         // Byte address
        logic [7:0]       data;         // Byte to push
    } cie_push_s;

    // Instruction pipeline status from the core
    typedef struct packed {
        logic             boundary;     // Current instruction completes this cycle
        logic             sei;          // Set-enable completes
        logic             cli;          // Clear-enable completes
        logic             return_from_interrupt;         // Return instruction starts
        logic             sleeping;     // Core is in sleep
    } cie_core_s;

endpackage

// *** cie_irq_unit.sv ***
// Interrupt entry and exit sequencer with source arbitration
`timescale 1ns/1ps
`default_nettype none
module cie_irq_unit #(
    parameter int NSRC = cie_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    // Peripheral sources
    input wire logic [NSRC-1:0] I_SRC_EVENT,        // Condition pulse or level, async
    input wire logic [NSRC-1:0] I_SRC_IS_LEVEL,     // Source type, static
    input wire logic [NSRC-1:0] I_SRC_ENABLE,       // Individual enables
    input wire logic [NSRC-1:0] I_FLAG_CLR_WR,      // Software write strobe of ones
    output logic [NSRC-1:0] O_FLAGS,                // Pending flags
    // Control bits
    input wire logic I_VECTOR_SELECT_BOOT,
    input wire logic I_BOOT_RESET_VECTOR_FUSE,
    input wire logic I_BOOT_LOCK_APP_BITS,
    input wire logic I_BOOT_LOCK_BOOT_BITS,
    input wire logic [cie_pkg::PC_W-1:0] I_BOOT_START,
    input wire logic I_GIE_WR,                      // Software write of global enable
    input wire logic I_GIE_WR_VAL,
    output logic O_GIE,
    // Core pipeline
    input wire cie_pkg::cie_core_s I_CORE,
    input wire logic [cie_pkg::PC_W-1:0] I_PC,      // Next program counter to resume
    input wire logic [7:0] I_POP_DATA,              // Stack byte read at O_SP+1
    input wire logic [cie_pkg::SP_W-1:0] I_SP_WR_VAL,
    input wire logic I_SP_WR,
    output cie_pkg::cie_push_s O_PUSH,
    output logic [cie_pkg::SP_W-1:0] O_SP,
    output logic O_STALL,                           // Core holds while high
    output logic O_PC_LOAD,                         // One-cycle load of O_PC_VAL
    output logic [cie_pkg::PC_W-1:0] O_PC_VAL
);
    import cie_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,   // Executing program
        ST_ENTRY = 2'b01,   // Pushing return address
        ST_RETURN_FROM_INTERRUPT  = 2'b10    // Popping return address
    } cie_state_e;

    cie_state_e state_reg;
    logic [NSRC-1:0] ev_meta_reg;       // First synchroniser stage
    logic [NSRC-1:0] ev_sync_reg;       // Second stage
    logic [NSRC-1:0] ev_last_reg;       // For edge detect of flag sources
    logic [NSRC-1:0] flag_reg;
    logic gie_reg;
    logic hold_one_reg;                 // One instruction must run first
    logic [3:0] cnt_reg;                // Four bits so a wake entry can count eight
    logic [SP_W-1:0] sp_reg;
    logic [PC_W-1:0] ret_pc_reg;
    logic [$clog2(NSRC)-1:0] sel_reg;
    logic started_reg;                  // First cycle after reset done
    logic [NSRC-1:0] req;
    logic [NSRC-1:0] pend;
    logic [$clog2(NSRC)-1:0] win;
    logic any_req;
    logic in_boot;
    logic lock_block;
    logic take;

    // Lowest index is lowest vector address
    function automatic logic [$clog2(NSRC)-1:0] pick_lowest(input logic [NSRC-1:0] v);
        logic [$clog2(NSRC)-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[$clog2(NSRC)-1:0];
            end
        end
        return r;
    endfunction

    // Vector address of a source, boot or low area
    function automatic logic [PC_W-1:0] vec_addr(input logic [$clog2(NSRC)-1:0] s, input logic boot,
                                                 input logic [PC_W-1:0] base);
        logic [PC_W-1:0] off;
        off = VEC_BASE + PC_W'(s) * PC_W'(VEC_STEP);
        return boot ? base + off : off;
    endfunction

    // ----------------------------------------
    // Input synchroniser
    // ----------------------------------------
    // Sources may toggle on other clocks; two stages before any use
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            ev_meta_reg <= '0;
            ev_sync_reg <= '0;
            ev_last_reg <= '0;
        end else begin
            ev_meta_reg <= I_SRC_EVENT;
            ev_sync_reg <= ev_meta_reg;
            ev_last_reg <= ev_sync_reg;
        end
    end

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    always_comb begin
        // Level sources have no flag and request only while present
        pend = (flag_reg & ~I_SRC_IS_LEVEL) | (ev_sync_reg & I_SRC_IS_LEVEL);
        req = pend & I_SRC_ENABLE;
        any_req = |req;
        win = pick_lowest(req);
        in_boot = (I_PC >= I_BOOT_START);
        // Boot lock: application lock masks while in app code, boot lock masks in boot code
        lock_block = (I_BOOT_LOCK_APP_BITS && !in_boot) || (I_BOOT_LOCK_BOOT_BITS && in_boot);
        // Clear-enable in this cycle blocks same-cycle take; set-enable needs one more instruction
        take = (state_reg == ST_RUN) && gie_reg && any_req && !lock_block
               && I_CORE.boundary && !I_CORE.cli && !hold_one_reg
               && !I_CORE.return_from_interrupt && started_reg;
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    // New event wins over a software clear in the same cycle
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            flag_reg <= '0;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (ev_sync_reg[i] && !ev_last_reg[i] && !I_SRC_IS_LEVEL[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (I_FLAG_CLR_WR[i]) begin
                    flag_reg[i] <= 1'b0;
                end else if (take && win == i[$clog2(NSRC)-1:0]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Global enable
    // ----------------------------------------
    // Only the enable bit lives here; other status bits are untouched
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            gie_reg <= 1'b0;
        end else if (take) begin
            gie_reg <= 1'b0;
        end else if (state_reg == ST_RETURN_FROM_INTERRUPT && cnt_reg == 4'h1) begin
            gie_reg <= 1'b1;
        end else if (I_CORE.cli) begin
            gie_reg <= 1'b0;
        end else if (I_CORE.sei) begin
            gie_reg <= 1'b1;
        end else if (I_GIE_WR) begin
            gie_reg <= I_GIE_WR_VAL;
        end
    end

    // ----------------------------------------
    // One-instruction hold after return or set-enable
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            hold_one_reg <= 1'b0;
        end else if ((state_reg == ST_RETURN_FROM_INTERRUPT && cnt_reg == 4'h1) || I_CORE.sei) begin
            hold_one_reg <= 1'b1;
        end else if (I_CORE.boundary && state_reg == ST_RUN) begin
            hold_one_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Reset start flag
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            state_reg <= ST_RUN;
            cnt_reg <= '0;
            sel_reg <= '0;
            ret_pc_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (take) begin
                        state_reg <= ST_ENTRY;
                        sel_reg <= win;
                        ret_pc_reg <= I_PC;
                        // Sleep wake costs four extra cycles
                        cnt_reg <= I_CORE.sleeping ? 4'(ENTRY_CYC) + 4'(WAKE_EXTRA) : 4'(ENTRY_CYC);
                    end else if (I_CORE.return_from_interrupt) begin
                        state_reg <= ST_RETURN_FROM_INTERRUPT;
                        cnt_reg <= 4'(RETURN_FROM_INTERRUPT_CYC);
                    end
                end
                ST_ENTRY: begin
                    if (cnt_reg == 4'h1) begin
                        state_reg <= ST_RUN;
                    end
                    cnt_reg <= cnt_reg - 4'h1;
                end
                ST_RETURN_FROM_INTERRUPT: begin
                    if (cnt_reg == 4'h3) begin
                        ret_pc_reg[PC_W-1:8] <= I_POP_DATA[PC_W-9:0];            // High byte first
                    end else if (cnt_reg == 4'h2) begin
                        ret_pc_reg[7:0] <= I_POP_DATA;
                    end
                    if (cnt_reg == 4'h1) begin
                        state_reg <= ST_RUN;
                    end
                    cnt_reg <= cnt_reg - 4'h1;
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Stack pointer and pushes
    // ----------------------------------------
    // Low byte pushed first at SP, high byte at SP-1; stack grows down
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            sp_reg <= SP_RESET;
            O_PUSH <= '0;
        end else begin
            O_PUSH <= '0;
            if (state_reg == ST_ENTRY && cnt_reg == 4'h2) begin
                O_PUSH <= '{valid: 1'b1, addr: sp_reg, data: ret_pc_reg[7:0]};
            end else if (state_reg == ST_ENTRY && cnt_reg == 4'h1) begin
                O_PUSH <= '{valid: 1'b1, addr: sp_reg - 16'h0001, data: {3'h0, ret_pc_reg[PC_W-1:8]}};
                sp_reg <= sp_reg - SP_STEP;
            end else if (state_reg == ST_RETURN_FROM_INTERRUPT && cnt_reg == 4'h3) begin
                sp_reg <= sp_reg + 16'h0001;
            end else if (state_reg == ST_RETURN_FROM_INTERRUPT && cnt_reg == 4'h2) begin
                sp_reg <= sp_reg + 16'h0001;
            end else if (I_SP_WR && state_reg == ST_RUN) begin
                sp_reg <= I_SP_WR_VAL;
            end
        end
    end

    // ----------------------------------------
    // Program counter loads
    // ----------------------------------------
    // Reset vector loaded once after reset; vectors relocate with select bit
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
            O_PC_LOAD <= 1'b0;
            O_PC_VAL <= '0;
        end else begin
            O_PC_LOAD <= 1'b0;
            if (!started_reg) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VAL <= I_BOOT_RESET_VECTOR_FUSE ? I_BOOT_START : RESET_VEC;
            end else if (state_reg == ST_ENTRY && cnt_reg == 4'h1) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VAL <= vec_addr(sel_reg, I_VECTOR_SELECT_BOOT, I_BOOT_START);
            end else if (state_reg == ST_RETURN_FROM_INTERRUPT && cnt_reg == 4'h1) begin
                O_PC_LOAD <= 1'b1;
                O_PC_VAL <= ret_pc_reg;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign O_FLAGS = flag_reg;
    assign O_GIE = gie_reg;
    assign O_SP = sp_reg;
    assign O_STALL = (state_reg != ST_RUN) || take;

endmodule
`default_nettype wire

// *** cie_irq_unit_assertions.sv ***
// Port-level checks of the interrupt entry and exit unit
`timescale 1ns/1ps
`default_nettype none
module cie_irq_unit_assertions
    import cie_pkg::*;
#(
    parameter int NSRC = 8
) (
    // Clock, reset and inputs
    input wire logic I_REF_CLK,
    input wire logic I_RST_B,
    input wire logic [NSRC-1:0] I_SRC_ENABLE,
    input wire logic I_BOOT_RESET_VECTOR_FUSE,
    input wire logic [cie_pkg::PC_W-1:0] I_BOOT_START,
    input wire cie_pkg::cie_core_s I_CORE,
    // Unit outputs
    input wire logic O_GIE,
    input wire cie_pkg::cie_push_s O_PUSH,
    input wire logic [cie_pkg::SP_W-1:0] O_SP,
    input wire logic O_STALL,
    input wire logic O_PC_LOAD,
    input wire logic [cie_pkg::PC_W-1:0] O_PC_VAL
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);
    logic [SP_W-1:0] sp_start_reg; // Stack pointer seen when a return starts
    // Kept so the pop count can be judged after the pointer has moved
    always_ff @(posedge I_REF_CLK) begin
        if (I_CORE.return_from_interrupt) begin
            sp_start_reg <= O_SP;
        end
    end
    // Entry begins at a boundary, never on a return
    sequence s_take;
        I_CORE.boundary && !I_CORE.return_from_interrupt && $rose(O_STALL);
    endsequence
    // Two back-to-back stack writes
    sequence s_push_pair;
        O_PUSH.valid ##1 O_PUSH.valid;
    endsequence
    property p_take_enabled; s_take |-> O_GIE && (I_SRC_ENABLE != '0); endproperty
    a_take_enabled: assert property (p_take_enabled) else $error("entry taken while disabled");
    property p_entry_clr; s_take |=> !O_GIE; endproperty
    a_entry_clr: assert property (p_entry_clr) else $error("global enable kept on entry");
    property p_entry_min; s_take |-> !O_PC_LOAD [*4]; endproperty
    a_entry_min: assert property (p_entry_min) else $error("vector loaded too early");
    property p_entry_push; s_take |-> ##[2:8] s_push_pair; endproperty
    a_entry_push: assert property (p_entry_push) else $error("return address not pushed");
    property p_push_dec; $rose(O_PUSH.valid) |=> O_PUSH.valid && (O_PUSH.addr == $past(O_PUSH.addr) - 16'h0001); endproperty
    a_push_dec: assert property (p_push_dec) else $error("second push not one byte lower");
    property p_sp_after; $fell(O_PUSH.valid) |-> O_SP == $past(O_PUSH.addr) - 16'h0001; endproperty
    a_sp_after: assert property (p_sp_after) else $error("stack pointer not lowered by two");
    property p_return_from_interrupt; I_CORE.return_from_interrupt |-> ##[3:6] (O_GIE && (O_SP == sp_start_reg + SP_STEP)); endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not restore enable and pointer");
    property p_cli; I_CORE.cli |-> !O_STALL; endproperty
    a_cli: assert property (p_cli) else $error("entry beside a clear-enable");
    property p_sei; I_CORE.sei |-> !O_STALL; endproperty
    a_sei: assert property (p_sei) else $error("entry beside a set-enable");
    // A return raises the stall one cycle after its pulse, so look one cycle back for it
    property p_boundary; $rose(O_STALL) |-> I_CORE.boundary || $past(I_CORE.return_from_interrupt); endproperty
    a_boundary: assert property (p_boundary) else $error("stall inside an instruction");
    property p_reset_vec;
        $rose(I_RST_B) |=> O_PC_LOAD && (O_PC_VAL == (I_BOOT_RESET_VECTOR_FUSE ? I_BOOT_START : RESET_VEC));
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("wrong reset vector");
endmodule
bind cie_irq_unit cie_irq_unit_assertions #(.NSRC(NSRC)) cie_irq_unit_assertions_i (.I_REF_CLK, .I_RST_B,
    .I_SRC_ENABLE, .I_BOOT_RESET_VECTOR_FUSE, .I_BOOT_START, .I_CORE, .O_GIE, .O_PUSH, .O_SP, .O_STALL,
    .O_PC_LOAD, .O_PC_VAL);
`default_nettype wire

// *** cie_stack_model.sv ***
// Stack memory standing behind the unit's push and pop ports
`timescale 1ns/1ps
`default_nettype none
module cie_stack_model
    import cie_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Unit side
    input wire cie_pkg::cie_push_s i_push,
    input wire logic [cie_pkg::SP_W-1:0] i_sp,
    output logic [7:0] o_pop_data
);
    logic [7:0] mem [0:255]; // Low page only, enough for the bench's stack
    logic [7:0] rd_addr; // Pop address, one above the pointer
    // Byte writes land on the clock edge that carries the strobe
    always_ff @(posedge i_clk) begin
        if (i_push.valid) begin
            mem[i_push.addr[7:0]] <= i_push.data;
        end
    end
    // Read answers at once, as the unit expects a combinational pop
    assign rd_addr = i_sp[7:0] + 8'h01;
    assign o_pop_data = mem[rd_addr];
endmodule
`default_nettype wire

// *** test_cie_irq_unit.sv ***
// Self-checking testbench of the interrupt entry and exit unit
`timescale 1ns/1ps
`default_nettype none
module test_cie_irq_unit;
    import cie_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    localparam logic [4:0] BND = 5'h10; // Boundary only
    localparam logic [12:0] BOOT = 13'h1000; // Boot section start
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] ev = 8'h00, lvl = 8'h00, en = 8'h00, clr = 8'h00, flags, pop;
    logic vsel = 1'b0, fuse = 1'b0, lk_app = 1'b0, lk_boot = 1'b0, gie_wr = 1'b0, gie_val = 1'b1, sp_wr = 1'b0;
    logic gie, stall, pc_load;
    logic [12:0] pc = 13'h0123, pc_val;
    logic [15:0] sp_val = 16'h0080, sp;
    cie_core_s core = '0;
    cie_push_s push;
    int fails = 0, n_checks = 0, cycles = 0, n, n_norm;
    always #5 clk = ~clk;
    cie_irq_unit #(.NSRC(8)) cie_irq_unit_i (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_SRC_EVENT(ev),
        .I_SRC_IS_LEVEL(lvl), .I_SRC_ENABLE(en), .I_FLAG_CLR_WR(clr), .O_FLAGS(flags), .I_VECTOR_SELECT_BOOT(vsel),
        .I_BOOT_RESET_VECTOR_FUSE(fuse), .I_BOOT_LOCK_APP_BITS(lk_app), .I_BOOT_LOCK_BOOT_BITS(lk_boot),
        .I_BOOT_START(BOOT), .I_GIE_WR(gie_wr), .I_GIE_WR_VAL(gie_val), .O_GIE(gie), .I_CORE(core), .I_PC(pc),
        .I_POP_DATA(pop), .I_SP_WR_VAL(sp_val), .I_SP_WR(sp_wr), .O_PUSH(push), .O_SP(sp), .O_STALL(stall),
        .O_PC_LOAD(pc_load), .O_PC_VAL(pc_val));
    cie_stack_model cie_stack_model_i (.i_clk(clk), .i_push(push), .i_sp(sp), .o_pop_data(pop));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Wait for the vector load, bounded so a dead unit cannot hang us
    task automatic wait_load(output int cnt);
        cnt = 0;
        while (pc_load !== 1'b1 && cnt < 20) begin
            cyc(1);
            cnt++;
        end
    endtask
    task automatic do_reset(input logic f, input logic [12:0] vec);
        fuse = f;
        rst_b = 1'b0;
        cyc(6);
        rst_b = 1'b1;
        wait_load(n);
        chk("reset vector", 16'(vec), 16'(pc_val));
    endtask
    // Source event held three cycles so the synchroniser sees it
    task automatic pulse(input int i);
        ev[i] = 1'b1;
        cyc(3);
        ev[i] = 1'b0;
        cyc(3);
    endtask
    // Boundary held for hold cycles; sleeping stays up through entry
    task automatic take(input logic [12:0] vec, input logic [4:0] op, input int hold, output int cnt);
        core = op;
        cyc(hold);
        core = op & 5'h01;
        wait_load(cnt);
        chk("vector", 16'(vec), 16'(pc_val));
    endtask
    task automatic no_take(input logic [4:0] op);
        core = op;
        #1 chk("stall", 16'h0000, 16'(stall));
        cyc(1);
        core = '0;
        repeat (6) begin
            cyc(1);
            chk("load", 16'h0000, 16'(pc_load));
        end
    endtask
    task automatic ret(input logic [12:0] exp_pc, input logic [15:0] exp_sp);
        core = 5'h02;
        cyc(1);
        core = '0;
        wait_load(n);
        chk("return pc", 16'(exp_pc), 16'(pc_val));
        cyc(2);
        chk("gie after return", 16'h0001, 16'(gie));
        chk("sp after return", exp_sp, sp);
    endtask
    task automatic set_gie();
        gie_wr = 1'b1;
        cyc(1);
        gie_wr = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        do_reset(1'b1, BOOT);
        do_reset(1'b0, 13'h0000);
        sp_wr = 1'b1;
        set_gie();
        sp_wr = 1'b0;
        pulse(3);
        chk("flag while disabled", 16'h0008, 16'(flags));
        no_take(BND);
        en = 8'h7F;
        take(13'h0008, BND, 1, n_norm);
        chk("entry at least four", 16'h0001, 16'(n_norm >= 4));
        chk("flag after entry", 16'h0000, 16'(flags));
        chk("gie after entry", 16'h0000, 16'(gie));
        chk("sp after entry", 16'h007E, sp);
        pc = 13'h0456;
        set_gie();
        pulse(1);
        take(13'h0004, BND, 1, n);
        ret(13'h0456, 16'h007E);
        ret(13'h0123, 16'h0080);
        $display("test entry and nesting finished");
        no_take(BND);
        pulse(5);
        pulse(2);
        no_take(5'h14);
        chk("gie after clear", 16'h0000, 16'(gie));
        no_take(BND);
        no_take(5'h18);
        take(13'h0006, BND, 2, n);
        ret(13'h0456, 16'h0080);
        no_take(BND);
        take(13'h000C, BND, 1, n);
        ret(13'h0456, 16'h0080);
        $display("test priority and enable timing finished");
        pulse(0);
        clr = 8'hFE;
        cyc(1);
        clr = 8'h00;
        chk("flag kept on zero write", 16'h0001, 16'(flags));
        clr = 8'h01;
        cyc(1);
        clr = 8'h00;
        chk("flag cleared on one write", 16'h0000, 16'(flags));
        vsel = 1'b1;
        pulse(4);
        take(BOOT + 13'h000A, BND, 2, n);
        ret(13'h0456, 16'h0080);
        vsel = 1'b0;
        no_take(BND);
        lk_app = 1'b1;
        pc = 13'h0100;
        pulse(6);
        no_take(BND);
        lk_app = 1'b0;
        lk_boot = 1'b1;
        pc = 13'h1100;
        no_take(BND);
        lk_boot = 1'b0;
        take(13'h000E, BND, 1, n);
        ret(13'h1100, 16'h0080);
        $display("test flags, relocation and locks finished");
        no_take(BND);
        lvl = 8'h80;
        pulse(7);
        en = 8'hFF;
        no_take(BND);
        ev[7] = 1'b1;
        cyc(3);
        take(13'h0010, BND, 1, n);
        ev[7] = 1'b0;
        chk("no flag on level source", 16'h0000, 16'(flags));
        ret(13'h1100, 16'h0080);
        no_take(BND);
        pulse(1);
        take(13'h0004, 5'h11, 1, n);
        core = '0;
        chk("wake extra cycles", 16'h0004, 16'(n - n_norm));
        ret(13'h1100, 16'h0080);
        $display("test level source and wake finished");
        tally_and_finish();
    end
endmodule
`default_nettype wire
